// ==== rso_encoder.sv ====
`timescale 1ns/1ps
module rso_encoder (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // Alarm sources, unit 0 is the control unit
    input wire logic CTRL_BATTERY_ALARM_IN,
    input wire rso_pkg::rso_unit_alarm_t [rso_pkg::UNITS-1:0] UNIT_ALARM_IN,
    // Robot data, robot n at index n-1
    input wire rso_pkg::rso_axis_words_t [rso_pkg::ROBOTS-1:0] WORLD_COORD_IN,
    input wire rso_pkg::rso_axis_words_t [rso_pkg::ROBOTS-1:0] JOINT_TORQUE_IN,
    input wire rso_pkg::rso_robot_flags_t [rso_pkg::ROBOTS-1:0] ROBOT_FLAGS_IN,
    // Controller state, from logic on this clock
    input wire logic [rso_pkg::WORD_W-1:0] CPU_LOAD_IN,
    input wire logic EMERGENCY_STOP_IN,
    input wire logic [rso_pkg::FUNC_W-1:0] CURRENT_FUNCTION_IN,
    input wire logic AUTO_MODE_IN,
    input wire logic PROGRAM_MODE_IN,
    input wire logic REMOTE_SOURCE_IN,
    input wire logic REMOTE_IO_ENABLED_IN,
    // Pins from the master
    input wire logic HEARTBEAT_IN,
    input wire logic [rso_pkg::SEL_W-1:0] ROBOT_SELECTOR_IN,
    // Status outputs
    output logic CTRL_BATTERY_ALARM,
    output rso_pkg::rso_unit_alarm_t [rso_pkg::UNITS-1:0] UNIT_ALARM,
    output logic ANY_ALARM,
    output rso_pkg::rso_axis_words_t WORLD_COORD,
    output rso_pkg::rso_axis_words_t JOINT_TORQUE,
    output logic [rso_pkg::WORD_W-1:0] CPU_LOAD,
    output logic [rso_pkg::WORD_W-1:0] EMERGENCY_STOP_COUNT,
    output logic HEARTBEAT,
    output logic [rso_pkg::FUNC_W-1:0] CURRENT_FUNCTION,
    output logic REMOTE_ACCEPTABLE,
    output rso_pkg::rso_robot_flags_t ROBOT_FLAGS
);
    import rso_pkg::*;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic hb_meta_reg;
    logic hb_sync_reg;
    logic [SEL_W-1:0] sel_meta_reg;
    logic [SEL_W-1:0] sel_sync_reg;
    logic emergency_stop_count_prev_reg;

    // The selector may skew between bits while it changes; the master
    // settling wait covers that, so no bit-wise agreement is checked.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            hb_meta_reg <= 1'b0;
            hb_sync_reg <= 1'b0;
            sel_meta_reg <= '0;
            sel_sync_reg <= '0;
        end else begin
            hb_meta_reg <= HEARTBEAT_IN;
            hb_sync_reg <= hb_meta_reg;
            sel_meta_reg <= ROBOT_SELECTOR_IN;
            sel_sync_reg <= sel_meta_reg;
        end
    end

    // ---------------------------------------------------------------
    // Selection decode
    // ---------------------------------------------------------------
    // Index of the robot whose words are shown; zero means robot one.
    function automatic logic [SEL_W-1:0] word_index(input logic [SEL_W-1:0] sel);
        word_index = (sel == '0) ? '0 : sel - SEL_DEFAULT;
    endfunction : word_index

    // Selector values above sixteen do not name a robot.
    function automatic logic sel_valid(input logic [SEL_W-1:0] sel);
        sel_valid = (sel != '0) && (sel <= SEL_W'(ROBOTS));
    endfunction : sel_valid

    logic [SEL_W-1:0] widx;
    logic any_motor;
    logic all_home;
    logic any_high;
    logic any_cal;
    rso_robot_flags_t flags_next;
    logic alarm_next;

    assign widx = word_index(sel_sync_reg);

    // Aggregates over all robots for selector zero.
    always_comb begin
        any_motor = 1'b0;
        all_home = 1'b1;
        any_high = 1'b0;
        any_cal = 1'b0;
        for (int i = 0; i < ROBOTS; i++) begin
            any_motor = any_motor | ROBOT_FLAGS_IN[i].motors_energized;
            all_home = all_home & ROBOT_FLAGS_IN[i].at_home;
            any_high = any_high | ROBOT_FLAGS_IN[i].high_power_active;
            any_cal = any_cal | ROBOT_FLAGS_IN[i].calibration_required;
        end
    end

    // Flag source by selector; an out-of-range value shows all clear.
    always_comb begin
        flags_next = '0;
        if (sel_sync_reg == '0) begin
            flags_next.motors_energized = any_motor;
            flags_next.at_home = all_home;
            flags_next.high_power_active = any_high;
            flags_next.calibration_required = any_cal;
        end else if (sel_valid(sel_sync_reg)) begin
            flags_next = ROBOT_FLAGS_IN[widx];
        end
    end

    always_comb begin
        alarm_next = CTRL_BATTERY_ALARM_IN;
        for (int u = 0; u < UNITS; u++) begin
            alarm_next = alarm_next | UNIT_ALARM_IN[u].battery | UNIT_ALARM_IN[u].grease;
        end
    end

    // ---------------------------------------------------------------
    // Alarm outputs
    // ---------------------------------------------------------------
    // registered alarms
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            CTRL_BATTERY_ALARM <= 1'b0;
            UNIT_ALARM <= '0;
            ANY_ALARM <= 1'b0;
        end else begin
            CTRL_BATTERY_ALARM <= CTRL_BATTERY_ALARM_IN;
            UNIT_ALARM <= UNIT_ALARM_IN;
            ANY_ALARM <= alarm_next;
        end
    end

    // ---------------------------------------------------------------
    // Robot words and flags
    // ---------------------------------------------------------------
    // Words pass untouched, so their single-precision encoding is kept.
    // selected robot words
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            WORLD_COORD <= '0;
            JOINT_TORQUE <= '0;
        end else if (widx < SEL_W'(ROBOTS)) begin
            WORLD_COORD <= WORLD_COORD_IN[widx];
            JOINT_TORQUE <= JOINT_TORQUE_IN[widx];
        end else begin
            WORLD_COORD <= '0;
            JOINT_TORQUE <= '0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            ROBOT_FLAGS <= '0;
        end else begin
            ROBOT_FLAGS <= flags_next;
        end
    end

    // ---------------------------------------------------------------
    // Controller words
    // ---------------------------------------------------------------
    // load, function and remote status
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            CPU_LOAD <= WORD_RST;
            CURRENT_FUNCTION <= FUNC_RST;
            REMOTE_ACCEPTABLE <= 1'b0;
        end else begin
            CPU_LOAD <= CPU_LOAD_IN;
            CURRENT_FUNCTION <= CURRENT_FUNCTION_IN;
            REMOTE_ACCEPTABLE <= (AUTO_MODE_IN & REMOTE_SOURCE_IN)
                | (PROGRAM_MODE_IN & REMOTE_IO_ENABLED_IN);
        end
    end

    // The count wraps at the top; a real controller never gets there.
    // count stop events
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            emergency_stop_count_prev_reg <= 1'b0;
            EMERGENCY_STOP_COUNT <= WORD_RST;
        end else begin
            emergency_stop_count_prev_reg <= EMERGENCY_STOP_IN;
            if (EMERGENCY_STOP_IN && !emergency_stop_count_prev_reg) begin
                EMERGENCY_STOP_COUNT <= EMERGENCY_STOP_COUNT + EMERGENCY_STOP_COUNT_STEP;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            HEARTBEAT <= 1'b0;
        end else begin
            HEARTBEAT <= hb_sync_reg;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    // One edge of a stop input that was low at the edge before.
    sequence s_rise;
        EMERGENCY_STOP_IN && !emergency_stop_count_prev_reg;
    endsequence

    // A heartbeat change needs three flops to reach the output.
    sequence s_hb_toggle;
        $changed(HEARTBEAT_IN) ##3 1'b1;
    endsequence

    chk_alarm_follow: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        ##1 CTRL_BATTERY_ALARM == $past(CTRL_BATTERY_ALARM_IN))
        else $error("controller battery alarm did not follow");
    chk_unit_alarms: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        ##1 UNIT_ALARM == $past(UNIT_ALARM_IN))
        else $error("unit alarms did not follow");
    chk_any_alarm: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        ##1 ANY_ALARM == (CTRL_BATTERY_ALARM | (|UNIT_ALARM)))
        else $error("aggregate alarm wrong");
    chk_emergency_stop_count_count: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        s_rise |=> EMERGENCY_STOP_COUNT == $past(EMERGENCY_STOP_COUNT) + EMERGENCY_STOP_COUNT_STEP)
        else $error("stop count did not advance");
    chk_emergency_stop_count_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        !(EMERGENCY_STOP_IN && !emergency_stop_count_prev_reg) |=> $stable(EMERGENCY_STOP_COUNT))
        else $error("stop count moved without a stop");
    chk_heartbeat_echo: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        s_hb_toggle |-> HEARTBEAT == $past(HEARTBEAT_IN, 3))
        else $error("heartbeat not echoed in three cycles");
    chk_function_code: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        ##1 CURRENT_FUNCTION == $past(CURRENT_FUNCTION_IN))
        else $error("function code wrong");
    chk_remote_ok: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (!AUTO_MODE_IN && !PROGRAM_MODE_IN) |=> !REMOTE_ACCEPTABLE)
        else $error("remote acceptable without a mode");
    chk_home_all: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (sel_sync_reg == '0 && !all_home) |=> !ROBOT_FLAGS.at_home)
        else $error("home shown with a robot away");
    chk_robot_one: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (RST_B && sel_sync_reg == '0) |=> WORLD_COORD == $past(WORLD_COORD_IN[0]))
        else $error("robot one words not shown");
    chk_reset_clear: assert property (@(posedge SYS_CLK)
        !RST_B |=> (!ANY_ALARM && !HEARTBEAT && EMERGENCY_STOP_COUNT == WORD_RST))
        else $error("outputs not cleared by reset");

    // ---------------------------------------------------------------
    // Selection and per-unit checks
    // ---------------------------------------------------------------
    // One battery and one grease check per unit, so a swapped pair shows.
    for (genvar u = 0; u < UNITS; u++) begin : g_unit_chk
        chk_unit_battery: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
            RST_B |=> UNIT_ALARM[u].battery == $past(UNIT_ALARM_IN[u].battery))
            else $error("unit battery alarm did not follow");
        chk_unit_grease: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
            RST_B |=> UNIT_ALARM[u].grease == $past(UNIT_ALARM_IN[u].grease))
            else $error("unit grease alarm did not follow");
    end

    chk_coord_select: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (RST_B && sel_valid(sel_sync_reg)) |=> WORLD_COORD == $past(WORLD_COORD_IN[widx]))
        else $error("coordinates not from the selected robot");
    chk_torque_select: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (RST_B && sel_valid(sel_sync_reg)) |=> JOINT_TORQUE == $past(JOINT_TORQUE_IN[widx]))
        else $error("torques not from the selected robot");
    chk_flags_single: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (RST_B && sel_valid(sel_sync_reg)) |=> ROBOT_FLAGS == $past(ROBOT_FLAGS_IN[widx]))
        else $error("flags not from the selected robot");
    chk_sel_refused: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (RST_B && sel_sync_reg != '0 && !sel_valid(sel_sync_reg))
        |=> (ROBOT_FLAGS == '0 && WORLD_COORD == '0 && JOINT_TORQUE == '0))
        else $error("out of range selector shows data");
    chk_motor_any: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (RST_B && sel_sync_reg == '0 && any_motor) |=> ROBOT_FLAGS.motors_energized)
        else $error("motors on not shown for all robots");
    chk_remote_cond: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        RST_B |=> REMOTE_ACCEPTABLE == $past((AUTO_MODE_IN && REMOTE_SOURCE_IN)
            || (PROGRAM_MODE_IN && REMOTE_IO_ENABLED_IN)))
        else $error("remote acceptable wrong");
    chk_cpu_load: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        RST_B |=> CPU_LOAD == $past(CPU_LOAD_IN))
        else $error("load word did not follow");
endmodule : rso_encoder

// ==== rso_pkg.sv ====
package rso_pkg;
    // ---------------------------------------------------------------
    // Sizes and reset values
    // ---------------------------------------------------------------
    localparam int ROBOTS = 16;
    localparam int SEL_W = 5;
    localparam int AXES = 6;
    localparam int WORD_W = 32;
    localparam int FUNC_W = 6;
    localparam int UNITS = 4;
    localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
    localparam logic [FUNC_W-1:0] FUNC_RST = 6'h00;
    localparam logic [SEL_W-1:0] SEL_DEFAULT = 5'h01;
    localparam logic [WORD_W-1:0] EMERGENCY_STOP_COUNT_STEP = 32'h0000_0001;

    // Six IEEE single-precision words for one robot.
    typedef logic [AXES-1:0][WORD_W-1:0] rso_axis_words_t;

    // Status flags of one robot.
    typedef struct packed {
        logic motors_energized;
        logic at_home;
        logic high_power_active;
        logic calibration_required;
    } rso_robot_flags_t;

    // Alarm flags of the robot on one unit.
    typedef struct packed {
        logic battery;
        logic grease;
    } rso_unit_alarm_t;
endpackage : rso_pkg

// ==== rso_master_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Master equipment model
// ----------------------------------------
module rso_master_model #(
    parameter int SETTLE = 8
) (
    // Clock
    input wire logic sys_clk,
    // Pins toward the controller
    output logic heartbeat_pin,
    output logic [rso_pkg::SEL_W-1:0] selector_pin
);
    import rso_pkg::*;

    // Both pins idle low until the bench asks for a change.
    initial begin
        heartbeat_pin = 1'b0;
        selector_pin = 5'h00;
    end

    task automatic toggle_heartbeat();
        @(posedge sys_clk);
        heartbeat_pin <= ~heartbeat_pin;
    endtask : toggle_heartbeat

    // selector settling wait.
    // The wait is far shorter than a real master's, to keep runs short.
    // Nothing is read back until the wait ends, so no mixed robot data is seen.
    task automatic select_robot(input logic [SEL_W-1:0] sel);
        @(posedge sys_clk);
        selector_pin <= sel;
        repeat (SETTLE) @(posedge sys_clk);
    endtask : select_robot
endmodule : rso_master_model

// ==== tb.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Status encoder bench
// ----------------------------------------
module tb;
    import rso_pkg::*;
    logic SYS_CLK, RST_B, ctrl_in, emergency_stop_count, hb_exp, ctrl_out, any_out, hb_out, acc_out, hb_pin;
    logic [3:0] mode;
    logic [SEL_W-1:0] sel_pin;
    logic [WORD_W-1:0] load_in, load_out, stop_out;
    logic [FUNC_W-1:0] func_in, func_out;
    rso_unit_alarm_t [UNITS-1:0] unit_in, unit_out;
    rso_axis_words_t [ROBOTS-1:0] coord_in, torque_in;
    rso_axis_words_t coord_out, torque_out;
    rso_robot_flags_t [ROBOTS-1:0] flags_in;
    rso_robot_flags_t flags_out, fexp;
    int failures, compares, k;

    rso_encoder i_rso_encoder (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .CTRL_BATTERY_ALARM_IN(ctrl_in),
        .UNIT_ALARM_IN(unit_in), .WORLD_COORD_IN(coord_in), .JOINT_TORQUE_IN(torque_in),
        .ROBOT_FLAGS_IN(flags_in), .CPU_LOAD_IN(load_in), .EMERGENCY_STOP_IN(emergency_stop_count),
        .CURRENT_FUNCTION_IN(func_in), .AUTO_MODE_IN(mode[3]), .PROGRAM_MODE_IN(mode[2]),
        .REMOTE_SOURCE_IN(mode[1]), .REMOTE_IO_ENABLED_IN(mode[0]), .HEARTBEAT_IN(hb_pin),
        .ROBOT_SELECTOR_IN(sel_pin), .CTRL_BATTERY_ALARM(ctrl_out), .UNIT_ALARM(unit_out),
        .ANY_ALARM(any_out), .WORLD_COORD(coord_out), .JOINT_TORQUE(torque_out),
        .CPU_LOAD(load_out), .EMERGENCY_STOP_COUNT(stop_out), .HEARTBEAT(hb_out),
        .CURRENT_FUNCTION(func_out), .REMOTE_ACCEPTABLE(acc_out), .ROBOT_FLAGS(flags_out));
    rso_master_model #(.SETTLE(8)) i_rso_master_model (.sys_clk(SYS_CLK),
        .heartbeat_pin(hb_pin), .selector_pin(sel_pin));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Waits whole cycles, then lets that edge's updates land.
    task automatic settle(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask : settle

    task automatic zero_check();
        check("outputs", 32'({ctrl_out, any_out, hb_out, acc_out, unit_out, func_out, flags_out,
            |coord_out, |torque_out, |load_out, |stop_out}), 32'h0);
    endtask : zero_check

    // Values above the robot count name no robot and must read back as zero.
    task automatic check_sel(input int s);
        bit off;
        rso_robot_flags_t want;
        i_rso_master_model.select_robot(5'(s));
        settle(1);
        off = (s > ROBOTS);
        k = (s == 0) ? 0 : s - 1;
        want = (s == 0) ? fexp : off ? 4'h0 : flags_in[k];
        for (int a = 0; a < AXES; a++) begin
            check("coord", coord_out[a], off ? WORD_RST : coord_in[k][a]);
            check("torque", torque_out[a], off ? WORD_RST : torque_in[k][a]);
        end
        check("flags", 32'(flags_out), 32'(want));
    endtask : check_sel

    task automatic final_report();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    initial begin
        SYS_CLK = 1'b0;
        forever #4 SYS_CLK = ~SYS_CLK;
    end

    // A hang is cut short here and counted as a mismatch.
    initial begin
        repeat (20000) @(posedge SYS_CLK);
        failures++;
        final_report();
    end

    initial begin
        {ctrl_in, emergency_stop_count, hb_exp, mode, load_in, func_in, unit_in, flags_in} = '0;
        RST_B = 1'b0;
        for (int r = 0; r < ROBOTS; r++) begin
            for (int a = 0; a < AXES; a++) begin
                coord_in[r][a] = 32'h3F80_0000 + 32'(r * 32'h100 + a);
                torque_in[r][a] = 32'hC040_0000 + 32'(r * 32'h100 + a);
            end
        end
        settle(20);
        zero_check();
        @(posedge SYS_CLK);
        RST_B <= 1'b1;
        // Patterns: one robot busy, all home, then distinct flags per robot.
        for (int p = 2; p >= 0; p--) begin
            @(posedge SYS_CLK);
            for (int r = 0; r < ROBOTS; r++) begin
                flags_in[r] <= (p == 0) ? 4'(r)
                    : (p == 1) ? 4'(r) | 4'h4 : (r == 15) ? 4'hB : 4'h4;
            end
            settle(0);
            fexp = 4'h4;
            for (int r = 0; r < ROBOTS; r++) begin
                fexp = (fexp | (flags_in[r] & 4'hB)) & (flags_in[r] | 4'hB);
            end
            check_sel(0);
        end
        for (int s = 1; s < 18; s++) begin
            check_sel(s);
        end
        for (int i = 0; i < 4; i++) begin
            i_rso_master_model.toggle_heartbeat();
            hb_exp = ~hb_exp;
            settle(3);
            check("heartbeat", 32'(hb_out), 32'(hb_exp));
        end
        for (int b = 0; b < 10; b++) begin
            @(posedge SYS_CLK);
            ctrl_in <= (b == 0);
            unit_in <= (b > 0 && b < 9) ? 8'(9'h1 << (b - 1)) : 8'h00;
            settle(1);
            check("ctrl alarm", 32'(ctrl_out), 32'(b == 0));
            check("unit alarm", 32'(unit_out), 32'(unit_in));
            check("any alarm", 32'(any_out), 32'(b < 9));
        end
        for (int f = 0; f < 64; f++) begin
            @(posedge SYS_CLK);
            func_in <= 6'(f);
            settle(1);
            check("function", 32'(func_out), 32'(f));
        end
        for (int m = 0; m < 16; m++) begin
            @(posedge SYS_CLK);
            mode <= 4'(m);
            settle(1);
            check("remote", 32'(acc_out), 32'(((m >> 3) & (m >> 1) | (m >> 2) & m) & 1));
        end
        @(posedge SYS_CLK);
        load_in <= 32'h3F4C_CCCD;
        settle(1);
        check("cpu load", load_out, 32'h3F4C_CCCD);
        // The last stop is held high for seven cycles and must count once.
        for (int i = 1; i <= 3; i++) begin
            @(posedge SYS_CLK);
            emergency_stop_count <= 1'b1;
            settle(i * 2);
            check("stop count", stop_out, 32'(i));
            @(posedge SYS_CLK);
            emergency_stop_count <= 1'b0;
        end
        @(posedge SYS_CLK);
        RST_B <= 1'b0;
        settle(1);
        zero_check();
        final_report();
    end
endmodule : tb
